/* uhb_pkg.sv */
// Constants shared by the serial controller host port and its buffers
package uhb_pkg;
    // Register select indices
    localparam logic [2:0] UHB_REG_DATA = 3'h0;
    localparam logic [2:0] UHB_REG_ERR = 3'h1;
    localparam logic [2:0] UHB_REG_TRIG = 3'h2;
    localparam logic [2:0] UHB_REG_RXCNT = 3'h3;
    localparam logic [2:0] UHB_REG_TXCNT = 3'h4;
    localparam logic [2:0] UHB_REG_STAT = 3'h5;
    // Buffer sizes and flag width
    localparam int UHB_FIFO_DEPTH = 16;
    localparam int UHB_ERR_W = 3;
    // Receive fill thresholds selected by the trigger field
    localparam logic [4:0] UHB_TRIG_L0 = 5'h01;
    localparam logic [4:0] UHB_TRIG_L1 = 5'h04;
    localparam logic [4:0] UHB_TRIG_L2 = 5'h08;
    localparam logic [4:0] UHB_TRIG_L3 = 5'h0E;
    localparam logic [1:0] UHB_TRIG_RST = 2'h0;
    // Pin vector layout: {sel[2:0], cs1st, cs2nd, cs3rd_n, rd_h, rd_l_n, wr_h, wr_l_n, as, d[7:0]}
    localparam int UHB_PIN_W = 19;
    localparam int UHB_P_SEL = 16;
    localparam int UHB_P_CS0 = 15;
    localparam int UHB_P_CS1 = 14;
    localparam int UHB_P_CS2N = 13;
    localparam int UHB_P_RDH = 12;
    localparam int UHB_P_RDLN = 11;
    localparam int UHB_P_WRH = 10;
    localparam int UHB_P_WRLN = 9;
    localparam int UHB_P_AS = 8;
    // Idle pin levels after reset: strobes and the low select inactive
    localparam logic [18:0] UHB_PIN_RST = 19'h02A00;
endpackage

/* uhb_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides and a fill count
`timescale 1ns/1ns
module uhb_fifo
    import uhb_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Occupancy
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Full and empty straight from the count, never guessed from pointers
    assign in_ready = (count_q != CW'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data = mem_q[rd_ptr_q];
    assign count = count_q;

    // Pointer wrap for any depth, not only powers of two
    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        return (p == AW'(DEPTH-1)) ? '0 : AW'(p + 1'b1);
    endfunction

    // Storage is written only, so it needs no reset
    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) wr_ptr_q <= nxt(wr_ptr_q);
            if (pop) rd_ptr_q <= nxt(rd_ptr_q);
            count_q <= CW'(count_q + CW'(push) - CW'(pop));
        end
    end

    a_fifo_bound: assert property (@(posedge clock) disable iff (!arst_n)
        count_q <= CW'(DEPTH)) else $error("fifo count above depth");
endmodule

/* uhb_host_port.sv */
// Host parallel port of the serial controller: selects, strobes, data bus, buffers
`timescale 1ns/1ns
module uhb_host_port
    import uhb_pkg::*;
#(
    parameter int DEPTH = UHB_FIFO_DEPTH,
    parameter int ERR_W = UHB_ERR_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Register select and chip selects
    input wire logic reg_select_bit_low,
    input wire logic reg_select_bit_mid,
    input wire logic reg_select_bit_high,
    input wire logic chip_select_first,
    input wire logic chip_select_second,
    input wire logic chip_select_low_third_n,
    input wire logic address_latch_strobe,
    // Strobes
    input wire logic read_strobe_high,
    input wire logic read_strobe_low_n,
    input wire logic write_strobe_high,
    input wire logic write_strobe_low_n,
    // Host data bus, split into three signals
    input wire logic [7:0] host_data_bus_in,
    output logic [7:0] host_data_bus_out,
    output logic host_data_bus_oe,
    output logic bus_drive_disable_n,
    // Transmit byte stream to the serializer
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    // Received characters with their error flags
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic [ERR_W-1:0] rx_err,
    output logic rx_data_request
);
    localparam int CW = $clog2(DEPTH+1);

    logic [UHB_PIN_W-1:0] pin_meta_q;
    logic [UHB_PIN_W-1:0] pin_q;
    logic [5:0] lat_q;
    logic wr_act_q;
    logic rd_act_q;
    logic [7:0] wr_data_q;
    logic [7:0] rd_data_q;
    logic [1:0] trig_q;
    logic [CW-1:0] tx_count;
    logic [CW-1:0] rx_count;
    logic [7+ERR_W:0] rx_head;
    logic rx_have;
    logic tx_room;

    // All pins cross two flops; only the second stage is read anywhere
    wire [UHB_PIN_W-1:0] pin_raw = {reg_select_bit_high, reg_select_bit_mid,
        reg_select_bit_low, chip_select_first, chip_select_second,
        chip_select_low_third_n, read_strobe_high, read_strobe_low_n,
        write_strobe_high, write_strobe_low_n, address_latch_strobe, host_data_bus_in};
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pin_meta_q <= UHB_PIN_RST;
            pin_q <= UHB_PIN_RST;
        end else begin
            pin_meta_q <= pin_raw;
            pin_q <= pin_meta_q;
        end
    end

    // Live address and chip selects after synchronising
    wire [5:0] addr_live = pin_q[UHB_P_SEL+2:UHB_P_CS2N];
    wire as_s = pin_q[UHB_P_AS];

    // Latch follows while strobe is low and freezes on its rise
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lat_q <= '0;
        end else if (!as_s) begin
            lat_q <= addr_live;
        end
    end
    // Strobe held low keeps the path transparent
    wire [5:0] addr_eff = as_s ? lat_q : addr_live;
    wire [2:0] sel = addr_eff[5:3];
    wire selected = addr_eff[2] && addr_eff[1] && !addr_eff[0];

    // Either strobe polarity starts an access
    wire rd_act = pin_q[UHB_P_RDH] || !pin_q[UHB_P_RDLN];
    wire wr_act = pin_q[UHB_P_WRH] || !pin_q[UHB_P_WRLN];
    wire reading = selected && rd_act;
    wire writing = selected && wr_act;

    // Access ends on the trailing edge, so data is stable before it is used
    wire wr_end = wr_act_q && !writing;
    wire rd_end = rd_act_q && !reading;
    wire tx_push = wr_end && (sel == UHB_REG_DATA);
    wire rx_pop = rd_end && (sel == UHB_REG_DATA);
    wire trig_wr = wr_end && (sel == UHB_REG_TRIG);

    // Access tracking and write data capture
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_act_q <= 1'b0;
            rd_act_q <= 1'b0;
            wr_data_q <= '0;
            trig_q <= UHB_TRIG_RST;
        end else begin
            wr_act_q <= writing;
            rd_act_q <= reading;
            if (writing) wr_data_q <= pin_q[7:0];
            if (trig_wr) trig_q <= wr_data_q[1:0];
        end
    end

    // Buffers: bytes in, bytes plus flags out
    uhb_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
        .clock(clock),
        .arst_n(arst_n),
        .in_valid(tx_push),
        .in_ready(tx_room),
        .in_data(wr_data_q),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(tx_data),
        .count(tx_count)
    );
    uhb_fifo #(.WIDTH(8+ERR_W), .DEPTH(DEPTH)) u_rx_fifo (
        .clock(clock),
        .arst_n(arst_n),
        .in_valid(rx_valid),
        .in_ready(rx_ready),
        .in_data({rx_err, rx_data}),
        .out_valid(rx_have),
        .out_ready(rx_pop),
        .out_data(rx_head),
        .count(rx_count)
    );

    // Threshold lookup; a write to a full buffer is dropped, never overwrites
    wire [4:0] trig_lvl = (trig_q == 2'h0) ? UHB_TRIG_L0 :
        (trig_q == 2'h1) ? UHB_TRIG_L1 :
        (trig_q == 2'h2) ? UHB_TRIG_L2 : UHB_TRIG_L3;
    assign rx_data_request = (5'(rx_count) >= trig_lvl);

    // Read multiplexer; bit zero maps to bus bit zero
    wire [7:0] rd_mux =
        (sel == UHB_REG_DATA) ? (rx_have ? rx_head[7:0] : 8'h00) :
        (sel == UHB_REG_ERR) ? (rx_have ? 8'(rx_head[7+ERR_W:8]) : 8'h00) :
        (sel == UHB_REG_TRIG) ? {6'h00, trig_q} :
        (sel == UHB_REG_RXCNT) ? 8'(rx_count) :
        (sel == UHB_REG_TXCNT) ? 8'(tx_count) :
        (sel == UHB_REG_STAT) ? {5'h00, rx_data_request, !tx_room, rx_have} : 8'h00;

    // Output data from a flop, frozen during the read so the host sees one value
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_q <= '0;
        end else if (!rd_act_q) begin
            rd_data_q <= rd_mux;
        end
    end

    // Drive only while a selected read is in progress
    assign host_data_bus_out = rd_data_q;
    assign host_data_bus_oe = rd_act_q;
    assign bus_drive_disable_n = !rd_act_q;

    // Checks
    // Falling edge of a selected write; the push follows on the same edge
    sequence s_write_done;
        writing ##1 !writing;
    endsequence
    sequence s_read_start;
        !reading ##1 reading;
    endsequence

    // Bus drive only ever follows a cycle in which the effective (live or latched) chip selects matched
    a_select_decode: assert property (@(posedge clock) disable iff (!arst_n)
        host_data_bus_oe |-> $past(addr_eff[2] && addr_eff[1] && !addr_eff[0]))
        else $error("bus driven while unselected");
    a_read_drives: assert property (@(posedge clock) disable iff (!arst_n)
        s_read_start |=> host_data_bus_oe)
        else $error("read did not drive bus");
    a_bus_release: assert property (@(posedge clock) disable iff (!arst_n)
        !reading |=> !host_data_bus_oe)
        else $error("bus driven without read");
    a_disable_pin: assert property (@(posedge clock) disable iff (!arst_n)
        reading |=> !bus_drive_disable_n)
        else $error("drive disable not low during read");
    a_low_strobe: assert property (@(posedge clock) disable iff (!arst_n)
        (selected && !pin_q[UHB_P_RDLN]) |=> host_data_bus_oe)
        else $error("low read strobe ignored");
    // Count checked one cycle after the push; a pop in the same cycle is excluded by the antecedent
    a_write_push: assert property (@(posedge clock) disable iff (!arst_n)
        (s_write_done ##0 (sel == UHB_REG_DATA && tx_room && !(tx_valid && tx_ready)))
        |=> tx_count == CW'($past(tx_count) + 1'b1))
        else $error("write did not enter buffer");
    a_latch_hold: assert property (@(posedge clock) disable iff (!arst_n)
        (as_s && $past(as_s)) |-> $stable(lat_q))
        else $error("latched address moved");
    a_data_stable: assert property (@(posedge clock) disable iff (!arst_n)
        (host_data_bus_oe && $past(host_data_bus_oe)) |-> $stable(host_data_bus_out))
        else $error("read data changed mid read");
    a_head_byte: assert property (@(posedge clock) disable iff (!arst_n)
        (!rd_act_q && rx_have && sel == UHB_REG_DATA) |=> rd_data_q == $past(rx_head[7:0]))
        else $error("wrong byte presented");
    a_rx_trigger: assert property (@(posedge clock) disable iff (!arst_n)
        (trig_q == 2'h3 && rx_count == CW'(UHB_TRIG_L3)) |-> rx_data_request)
        else $error("threshold request missing");
endmodule

/* uhb_host_model.sv */
// Host processor model driving the port pins
`timescale 1ns/1ns
module uhb_host_model (
    // Clock
    input wire logic clock,
    // Pins to the port, strb = {rd_h, rd_l_n, wr_h, wr_l_n}
    output logic [2:0] sel,
    output logic [2:0] cs,
    output logic as,
    output logic [3:0] strb,
    // Data bus
    input wire logic [7:0] dout,
    input wire logic oe,
    input wire logic dis_n,
    output logic [7:0] bus
);
    logic drive = 1'b0;
    logic [7:0] hold = 8'h00;
    // Released bus toggles so stale data never matches
    always @(posedge clock) if (!drive) hold <= ~hold;
    assign bus = oe ? dout : hold;
    initial begin
        sel = 3'h0;
        cs = 3'b110;
        as = 1'b0;
        strb = 4'b0101;
    end
    // One access; lat latches selects then scrambles the pins
    task automatic access(input bit wr, input bit hi, input bit lat,
            input logic [2:0] idx, input logic [2:0] csv, input logic [7:0] d,
            output logic [7:0] q, output logic q_oe, output logic q_dis);
        @(negedge clock);
        sel = idx;
        cs = csv;
        drive = wr;
        hold = d;
        if (lat) begin
            repeat (3) @(negedge clock);
            as = 1'b1;
            repeat (3) @(negedge clock);
            sel = ~idx;
            cs = 3'b001;
        end
        strb = wr ? (hi ? 4'b0111 : 4'b0100) : (hi ? 4'b1101 : 4'b0001);
        repeat (5) @(negedge clock);
        q = dout;
        q_oe = oe;
        q_dis = dis_n;
        strb = 4'b0101;
        repeat (4) @(negedge clock);
        drive = 1'b0;
        as = 1'b0;
        repeat (2) @(negedge clock);
    endtask
endmodule

/* uhb_host_port_tb.sv */
// Self-checking bench for the host port
`timescale 1ns/1ns
module uhb_host_port_tb;
    import uhb_pkg::*;
    logic clock;
    logic arst_n;
    logic [2:0] sel;
    logic [2:0] cs;
    logic as;
    logic [3:0] strb;
    logic [7:0] bus;
    logic [7:0] dout;
    logic oe, dis_n, tx_valid, tx_ready, rx_valid, rx_ready, req, q_oe, q_dis;
    logic [7:0] tx_data;
    logic [7:0] rx_data;
    logic [2:0] rx_err;
    logic [7:0] q;
    logic [7:0] exp_tx[$];
    logic [10:0] exp_rx[$];
    logic [4:0] lvl[4] = '{UHB_TRIG_L0, UHB_TRIG_L1, UHB_TRIG_L2, UHB_TRIG_L3};
    logic [2:0] cs_off[3] = '{3'b010, 3'b100, 3'b111};
    int num_errors = 0;
    int compares = 0;
    uhb_host_model uhb_host_model_inst (.clock(clock), .sel(sel), .cs(cs), .as(as),
        .strb(strb), .dout(dout), .oe(oe), .dis_n(dis_n), .bus(bus));
    uhb_host_port uhb_host_port_inst (.clock(clock), .arst_n(arst_n),
        .reg_select_bit_low(sel[0]), .reg_select_bit_mid(sel[1]),
        .reg_select_bit_high(sel[2]), .chip_select_first(cs[2]),
        .chip_select_second(cs[1]), .chip_select_low_third_n(cs[0]),
        .address_latch_strobe(as), .read_strobe_high(strb[3]),
        .read_strobe_low_n(strb[2]), .write_strobe_high(strb[1]),
        .write_strobe_low_n(strb[0]), .host_data_bus_in(bus),
        .host_data_bus_out(dout), .host_data_bus_oe(oe), .bus_drive_disable_n(dis_n),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_err(rx_err),
        .rx_data_request(req));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Expected request level for a fill count and a threshold code
    function automatic logic [7:0] exp_req(input int n, input int t);
        return {7'h00, n >= int'(lvl[t])};
    endfunction
    // Expected status byte: request, transmit full, receive not empty
    function automatic logic [7:0] exp_stat(input bit r, input bit f, input bit h);
        return {5'h00, r, f, h};
    endfunction
    task automatic stop_test();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Read with a random strobe kind; bus turnaround checked each time
    task automatic rd(input logic [2:0] idx, input bit lat, output logic [7:0] v);
        uhb_host_model_inst.access(1'b0, 1'($urandom), lat, idx, 3'b110, 8'h00, v,
            q_oe, q_dis);
        check("read oe", {7'h00, q_oe}, 8'h01);
        check("read bus_drive_disable", {7'h00, q_dis}, 8'h00);
        check("idle oe", {7'h00, oe}, 8'h00);
    endtask
    task automatic wr(input logic [2:0] idx, input logic [2:0] csv, input logic [7:0] d);
        uhb_host_model_inst.access(1'b1, 1'($urandom), 1'b0, idx, csv, d, q, q_oe, q_dis);
        check("write oe", {7'h00, q_oe}, 8'h00);
    endtask
    // Transmit stream compared in order as it leaves
    always @(posedge clock) begin
        if (tx_valid && tx_ready) begin
            if (exp_tx.size() == 0) begin
                check("tx extra byte", 8'h01, 8'h00);
            end else begin
                check("tx byte", tx_data, exp_tx.pop_front());
            end
        end
    end
    initial begin
        #(8 * 40000);
        num_errors++;
        stop_test();
    end
    initial begin
        logic [7:0] v;
        logic [7:0] d;
        logic [10:0] e;
        void'($urandom(19360));
        arst_n = 1'b0;
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_err = 3'h0;
        repeat (2) @(negedge clock);
        check("rst oe", {6'h00, oe, dis_n}, 8'h01);
        check("rst flags", {5'h00, tx_valid, req, rx_ready}, 8'h01);
        arst_n = 1'b1;
        // Overfill the stalled transmit buffer; deselected writes are lost
        for (int i = 0; i <= UHB_FIFO_DEPTH; i++) begin
            d = 8'($urandom);
            wr(UHB_REG_DATA, 3'b110, d);
            if (i < UHB_FIFO_DEPTH) exp_tx.push_back(d);
            wr(UHB_REG_DATA, cs_off[i % 3], ~d);
        end
        rd(UHB_REG_TXCNT, 1'b0, v);
        check("tx count", v, 8'(UHB_FIFO_DEPTH));
        rd(UHB_REG_TXCNT, 1'b1, v);
        check("latched read", v, 8'(UHB_FIFO_DEPTH));
        rd(UHB_REG_STAT, 1'b0, v);
        check("tx full stat", v, exp_stat(1'b0, 1'b1, 1'b0));
        // Drain with random serializer stalls
        repeat (120) begin
            @(negedge clock);
            tx_ready = 1'($urandom);
        end
        tx_ready = 1'b1;
        repeat (4) @(negedge clock);
        check("tx left", 8'(exp_tx.size()), 8'h00);
        // Each receive threshold, filling the buffer until it refuses
        for (int t = 0; t < 4; t++) begin
            wr(UHB_REG_TRIG, 3'b110, 8'(t));
            for (int n = 1; n <= UHB_FIFO_DEPTH; n++) begin
                @(negedge clock);
                rx_valid = 1'b1;
                rx_data = 8'($urandom);
                rx_err = 3'($urandom);
                exp_rx.push_back({rx_err, rx_data});
                @(negedge clock);
                rx_valid = 1'b0;
                @(negedge clock);
                check("rx request", {7'h00, req}, exp_req(n, t));
            end
            check("rx full", {7'h00, rx_ready}, 8'h00);
            rd(UHB_REG_RXCNT, 1'b0, v);
            check("rx count", v, 8'(UHB_FIFO_DEPTH));
            rd(UHB_REG_TRIG, 1'b0, v);
            check("trig read", v, 8'(t));
            rd(UHB_REG_STAT, 1'b0, v);
            check("rx full stat", v, exp_stat(1'b1, 1'b0, 1'b1));
            while (exp_rx.size() > 0) begin
                e = exp_rx.pop_front();
                rd(UHB_REG_ERR, 1'b0, v);
                check("rx flags", v, {5'h00, e[10:8]});
                rd(UHB_REG_DATA, 1'b0, v);
                check("rx data", v, e[7:0]);
            end
        end
        rd(UHB_REG_DATA, 1'b0, v);
        check("empty read", v, 8'h00);
        rd(3'h7, 1'b0, v);
        check("unused read", v, 8'h00);
        stop_test();
    end
endmodule
